/* logic/uart_xf_defines.svh */
`ifndef UART_XF_DEFINES_SVH
`define UART_XF_DEFINES_SVH

// register byte offsets
`define XF_OFF_EFC       8'h00
`define XF_OFF_PFC       8'h04
`define XF_OFF_MCR       8'h08
`define XF_OFF_IER       8'h0C
`define XF_OFF_LFR       8'h10
`define XF_OFF_EFR       8'h14
`define XF_OFF_PAUSE2    8'h18
`define XF_OFF_MSR       8'h1C

// extra_features_control fields
`define XF_EFC_IRDA      7
`define XF_EFC_INV       5
`define XF_EFC_AUTODIR   4
`define XF_EFC_TXOFF     2
`define XF_EFC_RXOFF     1
`define XF_EFC_NINE      0
`define XF_EFC_MASK      8'hB7

// other fields
`define XF_MCR_DTR       0
`define XF_MCR_RTS       1
`define XF_IER_LSI       2
`define XF_IER_MSI       3
`define XF_EFR_SCD       5
`define XF_EFR_HWRTS     6
`define XF_MSR_CD        7
`define XF_MSR_RI        6
`define XF_MSR_DSR       5
`define XF_MSR_DCD       3
`define XF_MSR_TERI      2
`define XF_MSR_DDSR      1

// reset values
`define XF_RST_BYTE      8'h00
`define XF_RST_WORD      32'h0000_0000

`endif

/* logic/uart_xf_pkg.sv */
package uart_xf_pkg;

  // bus answer sequencer, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACC  = 3'b010,
    ST_ANS  = 3'b100
  } bus_st_t;

  typedef struct packed {
    bus_st_t     st;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [7:0]  efc;
    logic [7:0]  pfc;
    logic [7:0]  modem_control_reg;
    logic [7:0]  interrupt_enable_reg;
    logic [7:0]  lfr;
    logic [7:0]  enhanced_features_reg;
    logic [7:0]  pause2;
    logic [2:0]  pin_prev;
    logic [2:0]  msr_delta;
    logic        dir_active;
    logic        tx_on;
    logic        rx_flush;
    logic        rx_push;
    logic [7:0]  rx_data;
    logic        rx_perr;
    logic        ls_irq;
    logic        ms_irq;
    logic        rts_n;
    logic        dtr_n;
    logic        irda_quarter;
    logic        modem_mode;
  } xf_state_t;

endpackage : uart_xf_pkg

/* logic/uart_xf.sv */
`include "uart_xf_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module uart_xf #(
  parameter int GROUP_BIT = 1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        tx_fifo_write,
  input  wire logic        tx_last_bit_done,
  input  wire logic        tsr_busy,
  input  wire logic        flow_rts_n,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_char,
  input  wire logic        rx_parity,
  input  wire logic        rx_perr_in,
  input  wire logic        cd_n,
  input  wire logic        ri_n,
  input  wire logic        dsr_n,
  output logic             tx_on,
  output logic             rx_flush,
  output logic             rx_push,
  output logic [7:0]       rx_data,
  output logic             rx_perr,
  output logic             ls_irq,
  output logic             ms_irq,
  output logic             rts_n,
  output logic             dtr_n,
  output logic             irda_quarter,
  output logic             modem_mode
);

  uart_xf_pkg::xf_state_t r;
  uart_xf_pkg::xf_state_t n;

  logic       wr_en;
  logic       rd_taken;
  logic       hit_any;
  logic [7:0] rd_byte;
  logic [2:0] pins;
  logic [2:0] ms_set;
  logic       sc_on;
  logic       is_match;

  // one address compare, shared by read mux and write strobes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // modem status byte as seen by software
  function automatic logic [7:0] msr_view(input logic mm, input logic [2:0] p, input logic [2:0] d);
    msr_view = 8'h00;
    if (mm) begin
      msr_view[`XF_MSR_CD]   = p[2];
      msr_view[`XF_MSR_RI]   = p[1];
      msr_view[`XF_MSR_DSR]  = p[0];
      msr_view[`XF_MSR_DCD]  = d[2];
      msr_view[`XF_MSR_TERI] = d[1];
      msr_view[`XF_MSR_DDSR] = d[0];
    end
  endfunction : msr_view

  // bus decode
  always_comb begin
    wr_en    = psel && penable && r.pready && pwrite && !r.pslverr;
    rd_taken = psel && penable && r.pready && !pwrite && !r.pslverr;
    hit_any  = hit(paddr, `XF_OFF_EFC) || hit(paddr, `XF_OFF_PFC) || hit(paddr, `XF_OFF_MCR)
            || hit(paddr, `XF_OFF_IER) || hit(paddr, `XF_OFF_LFR) || hit(paddr, `XF_OFF_EFR)
            || hit(paddr, `XF_OFF_PAUSE2) || hit(paddr, `XF_OFF_MSR);
    pins     = {~cd_n, ~ri_n, ~dsr_n};
    sc_on    = r.enhanced_features_reg[`XF_EFR_SCD];
    is_match = (rx_char == r.pause2);
  end

  // read mux, reserved bits come back as zero
  always_comb begin
    rd_byte = `XF_RST_BYTE;
    if (hit(paddr, `XF_OFF_EFC)) begin
      rd_byte = r.efc & `XF_EFC_MASK;
    end else if (hit(paddr, `XF_OFF_PFC)) begin
      rd_byte = r.pfc;
    end else if (hit(paddr, `XF_OFF_MCR)) begin
      rd_byte = r.modem_control_reg;
    end else if (hit(paddr, `XF_OFF_IER)) begin
      rd_byte = r.interrupt_enable_reg;
    end else if (hit(paddr, `XF_OFF_LFR)) begin
      rd_byte = r.lfr;
    end else if (hit(paddr, `XF_OFF_EFR)) begin
      rd_byte = r.enhanced_features_reg;
    end else if (hit(paddr, `XF_OFF_PAUSE2)) begin
      rd_byte = r.pause2;
    end else if (hit(paddr, `XF_OFF_MSR)) begin
      rd_byte = msr_view(r.modem_mode, pins, r.msr_delta);
    end
  end

  // next state of the whole block
  always_comb begin
    n          = r;
    n.rx_flush = 1'b0;
    n.rx_push  = 1'b0;
    n.ls_irq   = 1'b0;

    // answer sequencer: one wait state, pready for one cycle
    case (r.st)
      uart_xf_pkg::ST_IDLE: begin
        n.pready = 1'b0;
        if (psel && !penable) begin
          n.st = uart_xf_pkg::ST_ACC;
        end
      end
      uart_xf_pkg::ST_ACC: begin
        if (psel && penable) begin
          n.st      = uart_xf_pkg::ST_ANS;
          n.pready  = 1'b1;
          n.pslverr = !hit_any;
          n.prdata  = (pwrite || !hit_any) ? `XF_RST_WORD : {24'h00_0000, rd_byte};
        end
      end
      uart_xf_pkg::ST_ANS: begin
        n.st      = uart_xf_pkg::ST_IDLE;
        n.pready  = 1'b0;
        n.pslverr = 1'b0;
      end
      default: begin
        n.st     = uart_xf_pkg::ST_IDLE;
        n.pready = 1'b0;
      end
    endcase

    // register writes at the edge that takes the transfer
    if (wr_en) begin
      if (hit(paddr, `XF_OFF_EFC)) n.efc = pwdata[7:0] & `XF_EFC_MASK;
      if (hit(paddr, `XF_OFF_PFC)) n.pfc = pwdata[7:0];
      if (hit(paddr, `XF_OFF_MCR)) n.modem_control_reg = pwdata[7:0];
      if (hit(paddr, `XF_OFF_IER)) n.interrupt_enable_reg = pwdata[7:0];
      if (hit(paddr, `XF_OFF_LFR)) n.lfr = pwdata[7:0];
      if (hit(paddr, `XF_OFF_EFR)) n.enhanced_features_reg = pwdata[7:0];
      if (hit(paddr, `XF_OFF_PAUSE2)) n.pause2 = pwdata[7:0];
    end

    // modem inputs: deltas only in modem mode, gpio registers never involved
    n.modem_mode = n.pfc[GROUP_BIT];
    n.pin_prev   = pins;
    ms_set       = {pins[2] ^ r.pin_prev[2], r.pin_prev[1] & ~pins[1], pins[0] ^ r.pin_prev[0]};
    if (!r.modem_mode) begin
      n.msr_delta = 3'b000;
    end else begin
      // only bits already reported are cleared, a new change wins
      n.msr_delta = (r.msr_delta & ~(rd_taken && hit(paddr, `XF_OFF_MSR) ?
                     {r.prdata[`XF_MSR_DCD], r.prdata[`XF_MSR_TERI], r.prdata[`XF_MSR_DDSR]} : 3'b000))
                    | ms_set;
    end
    n.ms_irq = n.modem_mode && n.interrupt_enable_reg[`XF_IER_MSI] && (n.msr_delta != 3'b000);
    n.dtr_n  = n.modem_mode ? !n.modem_control_reg[`XF_MCR_DTR] : 1'b1;

    // infrared pulse width select
    n.irda_quarter = n.efc[`XF_EFC_IRDA];

    // auto direction: set by a fifo write, ended by the last bit; set wins
    if (tx_fifo_write) begin
      n.dir_active = 1'b1;
    end else if (tx_last_bit_done) begin
      n.dir_active = 1'b0;
    end
    if (n.efc[`XF_EFC_AUTODIR]) begin
      n.rts_n = n.dir_active ? n.efc[`XF_EFC_INV] : !n.efc[`XF_EFC_INV];
    end else if (n.enhanced_features_reg[`XF_EFR_HWRTS]) begin
      n.rts_n = flow_rts_n;
    end else begin
      n.rts_n = !n.modem_control_reg[`XF_MCR_RTS];
    end

    // transmitter stops only once the shift register is idle
    if (!n.efc[`XF_EFC_TXOFF]) begin
      n.tx_on = 1'b1;
    end else if (!tsr_busy) begin
      n.tx_on = 1'b0;
    end

    // receive filter; hardware may flip the receiver enable in auto detect
    if (rx_valid) begin
      n.rx_data = rx_char;
      n.rx_perr = rx_perr_in;
      if (!r.efc[`XF_EFC_NINE]) begin
        n.rx_push = !r.efc[`XF_EFC_RXOFF];
      end else if (!sc_on) begin
        // parity marks addresses; they are always kept and flagged
        n.rx_push = rx_parity || !r.efc[`XF_EFC_RXOFF];
        n.rx_perr = rx_parity;
      end else if (rx_parity && is_match) begin
        n.rx_push              = 1'b1;
        n.rx_perr              = rx_parity;
        n.efc[`XF_EFC_RXOFF]   = 1'b0;
      end else if (rx_parity) begin
        n.efc[`XF_EFC_RXOFF]   = 1'b1;
      end else begin
        n.rx_push = !r.efc[`XF_EFC_RXOFF];
      end
    end
    n.ls_irq   = n.rx_push && n.rx_perr && r.interrupt_enable_reg[`XF_IER_LSI];
    // turning the receiver off flushes whatever partial data is held
    n.rx_flush = n.efc[`XF_EFC_RXOFF] && !r.efc[`XF_EFC_RXOFF];
  end

  // single state register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r              <= '0;
      r.st           <= uart_xf_pkg::ST_IDLE;
      r.tx_on        <= 1'b1;
      r.rts_n        <= 1'b1;
      r.dtr_n        <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end

  // outputs straight from the state register
  always_comb begin
    pready       = r.pready;
    pslverr      = r.pslverr;
    prdata       = r.prdata;
    tx_on        = r.tx_on;
    rx_flush     = r.rx_flush;
    rx_push      = r.rx_push;
    rx_data      = r.rx_data;
    rx_perr      = r.rx_perr;
    ls_irq       = r.ls_irq;
    ms_irq       = r.ms_irq;
    rts_n        = r.rts_n;
    dtr_n        = r.dtr_n;
    irda_quarter = r.irda_quarter;
    modem_mode   = r.modem_mode;
  end

  // answer comes one cycle into the access phase and lasts one cycle
  a_pready_timing: assert property (@(posedge pclk) disable iff (!presetn)
    ce && psel && penable && r.st == uart_xf_pkg::ST_ACC |=> pready ##1 (!pready || !ce))
    else $error("pready not one cycle after access start");

  a_gpio_no_delta: assert property (@(posedge pclk) disable iff (!presetn)
    !r.modem_mode ##1 (!r.modem_mode && $stable(r)) |-> r.msr_delta == 3'b000 && !ms_irq)
    else $error("modem status moved in gpio mode");

  a_dtr_follows: assert property (@(posedge pclk) disable iff (!presetn)
    dtr_n == (modem_mode ? !r.modem_control_reg[`XF_MCR_DTR] : 1'b1))
    else $error("dtr pin wrong for pin mode");

  a_autodir_assert: assert property (@(posedge pclk) disable iff (!presetn)
    ce && r.efc[`XF_EFC_AUTODIR] && tx_fifo_write && !wr_en |=> rts_n == r.efc[`XF_EFC_INV])
    else $error("direction pin not asserted after fifo write");

  a_autodir_release: assert property (@(posedge pclk) disable iff (!presetn)
    ce && r.efc[`XF_EFC_AUTODIR] && tx_last_bit_done && !tx_fifo_write && !wr_en
    |=> rts_n == !r.efc[`XF_EFC_INV])
    else $error("direction pin not released after last bit");

  a_tx_stop_wait: assert property (@(posedge pclk) disable iff (!presetn)
    ce && r.efc[`XF_EFC_TXOFF] && tsr_busy && r.tx_on && !wr_en |=> tx_on)
    else $error("transmitter stopped during a character");

  a_rx_flush: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(r.efc[`XF_EFC_RXOFF]) |-> rx_flush)
    else $error("no flush when receiver turned off");

  a_drop_data: assert property (@(posedge pclk) disable iff (!presetn)
    ce && r.efc[`XF_EFC_NINE] && !sc_on && r.efc[`XF_EFC_RXOFF] && rx_valid && !rx_parity |=> !rx_push)
    else $error("data kept while receiver off");

  a_addr_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ce && r.efc[`XF_EFC_NINE] && !sc_on && rx_valid && rx_parity |=> rx_push && rx_perr)
    else $error("address byte not stored with flag");

  a_auto_reject: assert property (@(posedge pclk) disable iff (!presetn)
    ce && r.efc[`XF_EFC_NINE] && sc_on && rx_valid && rx_parity && !is_match
    |=> !rx_push && r.efc[`XF_EFC_RXOFF])
    else $error("wrong address not rejected");

  a_auto_accept: assert property (@(posedge pclk) disable iff (!presetn)
    ce && r.efc[`XF_EFC_NINE] && sc_on && rx_valid && rx_parity && is_match
    |=> rx_push && rx_perr && !r.efc[`XF_EFC_RXOFF])
    else $error("matching address not accepted");

  // register-driven outputs and filter corners the bench reaches
  a_auto_drop_data: assert property (@(posedge pclk) disable iff (!presetn)
    ce && r.efc[`XF_EFC_NINE] && sc_on && r.efc[`XF_EFC_RXOFF] && rx_valid && !rx_parity |=> !rx_push)
    else $error("data kept while auto detect receiver off");

  a_tx_resume: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !wr_en && !r.efc[`XF_EFC_TXOFF] |=> tx_on)
    else $error("transmitter not enabled");

  a_rts_manual: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !wr_en && !r.efc[`XF_EFC_AUTODIR] && !r.enhanced_features_reg[`XF_EFR_HWRTS] |=> rts_n == !r.modem_control_reg[`XF_MCR_RTS])
    else $error("rts pin not from modem control");

  a_ls_irq_push: assert property (@(posedge pclk) disable iff (!presetn)
    ls_irq |-> rx_push && rx_perr)
    else $error("line status event without flagged push");

  a_irda_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_en && hit(paddr, `XF_OFF_EFC) |=> irda_quarter == $past(pwdata[`XF_EFC_IRDA]))
    else $error("infrared width not taken from write");

  a_nine_off_pass: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !r.efc[`XF_EFC_NINE] && rx_valid
    |=> rx_push == !$past(r.efc[`XF_EFC_RXOFF]) && rx_perr == $past(rx_perr_in))
    else $error("point to point byte handled wrongly");

endmodule : uart_xf

`default_nettype wire

/* verif/uart_xf_far.sv */
`timescale 1ns/1ps
`default_nettype none

// far side: transmit shift timing and the remote stations on the line
module uart_xf_far #(
  parameter int CHAR_CYC = 20
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tx_fifo_write,
  output logic            tsr_busy,
  output logic            tx_last_bit_done,
  output logic            rx_valid,
  output logic [7:0]      rx_char,
  output logic            rx_parity,
  output logic            rx_perr_in
);
  int cnt_r;

  // one character per write; a write while busy is not queued here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r            <= 0;
      tsr_busy         <= 1'b0;
      tx_last_bit_done <= 1'b0;
    end else begin
      tx_last_bit_done <= (cnt_r == 1);
      if (tx_fifo_write && cnt_r == 0) begin
        cnt_r    <= CHAR_CYC;
        tsr_busy <= 1'b1;
      end else if (cnt_r != 0) begin
        cnt_r    <= cnt_r - 1;
        tsr_busy <= (cnt_r != 1);
      end
    end
  end

  initial begin
    rx_valid   = 1'b0;
    rx_char    = 8'h00;
    rx_parity  = 1'b0;
    rx_perr_in = 1'b0;
  end

  // a station puts one character and its ninth bit on the line
  task automatic send(input logic [7:0] c, input logic p);
    @(posedge pclk);
    rx_valid  <= 1'b1;
    rx_char   <= c;
    rx_parity <= p;
    @(posedge pclk);
    rx_valid  <= 1'b0;
    rx_char   <= ~c; // released line must not show a stale value
    rx_parity <= ~p;
  endtask : send
endmodule : uart_xf_far

`default_nettype wire

/* verif/uart_rs485_extra_features_tb.sv */
`include "uart_xf_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module uart_rs485_extra_features_tb;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, rx_char, rx_data, ld;
  logic [31:0] pwdata, prdata, r;
  logic        tx_fifo_write, tx_last_bit_done, tsr_busy, flow_rts_n, rx_valid, rx_parity;
  logic        rx_perr_in, cd_n, ri_n, dsr_n, tx_on, rx_flush, rx_push, rx_perr, ls_irq;
  logic        ms_irq, rts_n, dtr_n, irda_quarter, modem_mode, lp;
  int          failures, checks, np, nf, nl, cyc;

  uart_xf i_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .tx_fifo_write, .tx_last_bit_done, .tsr_busy, .flow_rts_n, .rx_valid,
    .rx_char, .rx_parity, .rx_perr_in, .cd_n, .ri_n, .dsr_n, .tx_on, .rx_flush, .rx_push,
    .rx_data, .rx_perr, .ls_irq, .ms_irq, .rts_n, .dtr_n, .irda_quarter, .modem_mode);

  uart_xf_far i_far (.pclk, .presetn, .tx_fifo_write, .tsr_busy, .tx_last_bit_done,
    .rx_valid, .rx_char, .rx_parity, .rx_perr_in);

  always #4 pclk = ~pclk;

  // pulse outputs are counted here so no scenario can miss them
  always @(posedge pclk) begin
    cyc++;
    if (rx_push === 1'b1) begin
      np++;
      ld = rx_data;
      lp = rx_perr;
    end
    if (rx_flush === 1'b1) nf++;
    if (ls_irq === 1'b1) nl++;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt

  // apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    wt(2);
  endtask : wr

  task automatic txw();
    @(posedge pclk);
    tx_fifo_write <= 1'b1;
    @(posedge pclk);
    tx_fifo_write <= 1'b0;
  endtask : txw

  // send one character and check how many pushes it caused
  task automatic rx(input logic [7:0] c, input logic p, input int pushes);
    int n0;
    n0 = np;
    i_far.send(c, p);
    wt(3);
    chk("rx_push", np - n0, pushes);
  endtask : rx

  task automatic conclude();
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, tx_fifo_write} = '0;
    {ce, flow_rts_n, cd_n, ri_n, dsr_n} = 5'h1F;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    wt(2);
    chk("tx_on", tx_on, 1);
    chk("rts_n", rts_n, 1);
    // reserved bits and infrared width
    wr(`XF_OFF_EFC, 32'h0000_00FF);
    chk("irda_quarter", irda_quarter, 1);
    apb(1'b0, `XF_OFF_EFC, 0);
    chk("efc", r, 32'h0000_00B7);
    wr(`XF_OFF_EFC, 0);
    chk("irda_quarter", irda_quarter, 0);
    apb(1'b0, 8'h20, 0);
    chk("pslverr", err, 1);
    // gpio mode hides modem pins
    wr(`XF_OFF_MCR, 32'h0000_0003);
    wr(`XF_OFF_IER, 32'h0000_000C);
    cd_n <= 1'b0;
    wt(3);
    chk("dtr_n", dtr_n, 1);
    chk("ms_irq", ms_irq, 0);
    apb(1'b0, `XF_OFF_MSR, 0);
    chk("msr", r, 0);
    wr(`XF_OFF_PFC, 32'h0000_0002);
    chk("modem_mode", modem_mode, 1);
    chk("dtr_n", dtr_n, 0);
    apb(1'b0, `XF_OFF_MSR, 0);
    chk("msr_lvl", r[7:5], 3'b100);
    dsr_n <= 1'b0;
    wt(3);
    chk("ms_irq", ms_irq, 1);
    apb(1'b0, `XF_OFF_MSR, 0);
    chk("msr_dsr", r & 32'h0000_00E2, 32'h0000_00A2);
    // the read cleared the reported delta, so the request drops
    wt(1);
    chk("ms_irq", ms_irq, 0);
    // auto direction wins over modem control; flow control is left disabled
    wr(`XF_OFF_EFR, 0);
    flow_rts_n <= 1'b0;
    // transmitter stays on here; it is switched off later, mid character
    wr(`XF_OFF_EFC, 32'h0000_0010);
    txw();
    wt(2);
    chk("rts_n", rts_n, 0);
    wr(`XF_OFF_EFC, 32'h0000_0014);
    chk("tx_on", tx_on, 1);
    wt(25);
    chk("rts_n", rts_n, 1);
    chk("tx_on", tx_on, 0);
    wr(`XF_OFF_EFC, 32'h0000_0030);
    txw();
    wt(2);
    chk("rts_n", rts_n, 1);
    chk("tx_on", tx_on, 1);
    wt(25);
    chk("rts_n", rts_n, 0);
    // receiver off flushes partial data
    wr(`XF_OFF_EFC, 32'h0000_0002);
    // the all-ones write at the start turned the receiver off once already
    chk("rx_flush", nf, 2);
    // normal multidrop, controller drives receiver enable
    wr(`XF_OFF_LFR, 32'h0000_0038);
    wr(`XF_OFF_EFC, 32'h0000_0003);
    rx(8'h55, 1'b0, 0);
    rx(8'hA1, 1'b1, 1);
    chk("rx_data", ld, 8'hA1);
    chk("rx_perr", lp, 1);
    chk("ls_irq", nl, 1);
    wr(`XF_OFF_EFC, 32'h0000_0001);
    rx(8'h66, 1'b0, 1);
    chk("rx_perr", lp, 0);
    rx(8'hB2, 1'b1, 1);
    chk("rx_perr", lp, 1);
    // automatic address detection
    wr(`XF_OFF_EFR, 32'h0000_0020);
    wr(`XF_OFF_PAUSE2, 32'h0000_005A);
    wr(`XF_OFF_EFC, 32'h0000_0003);
    rx(8'h11, 1'b0, 0);
    rx(8'h33, 1'b1, 0);
    rx(8'h5A, 1'b1, 1);
    chk("rx_perr", lp, 1);
    chk("ls_irq", nl, 3);
    apb(1'b0, `XF_OFF_EFC, 0);
    chk("rx_off", r[1], 0);
    rx(8'h22, 1'b0, 1);
    rx(8'h5A, 1'b1, 1);
    chk("rx_perr", lp, 1);
    rx(8'h33, 1'b1, 0);
    apb(1'b0, `XF_OFF_EFC, 0);
    chk("rx_off", r[1], 1);
    rx(8'h22, 1'b0, 0);
    // point to point mode passes the line's own parity flag
    wr(`XF_OFF_EFR, 0);
    wr(`XF_OFF_EFC, 0);
    rx(8'h77, 1'b1, 1);
    chk("rx_perr", lp, 0);
    conclude();
  end
endmodule : uart_rs485_extra_features_tb

`default_nettype wire
